/* hw/fpu_stack_data_transfer.sv */
/*
 Stack data-transfer unit: eight-entry extended register stack with
 loads, stores, exchange, conditional moves and constant pushes,
 driven by commands over a classic Wishbone slave.
 Assumes the processor fetches memory operands into the operand words
 and collects stored results from the result words.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpu_stack_data_transfer_consts.svh"
// Behaviour
// [RULE_01] Operands come from stack or memory only
// [RULE_02] Registers selected relative to stack top
// [RULE_03] Memory operands use processor addressing modes
// [RULE_04] Stack holds extended-real values
// [RULE_05] Real load pushes converted memory real
// [RULE_06] Real load can push a stack copy
// [RULE_07] Integer load converts and pushes
// [RULE_08] Packed decimal load converts and pushes
// [RULE_09] Plain stores convert top, stack unchanged
// [RULE_10] Store-and-pop stores then pops once
// [RULE_11] Pop empties top, top pointer plus one
// [RULE_12] Real store-pop may target stack register
// [RULE_13] Exchange swaps selected register with top
// [RULE_14] Conditional move only when condition holds
// [RULE_15] Conditions come from integer flags
// [RULE_16] Eight carry/zero/parity condition variants
// [RULE_17] Conditional move presence is reported
// [RULE_18] Seven constants pushed onto the top
// [RULE_19] Constants have full 64-bit significand
// [RULE_20] Constants rounded under rounding control
// [RULE_21] Masked invalid decimal store writes indefinite
// [RULE_22] Decimal loads convert exactly
// [RULE_23] Push decrements top, writes, tags valid
// [RULE_24] Relative index is top plus i mod eight
module fpu_stack_data_transfer import fpu_stack_data_transfer_pkg::*; #(
   parameter logic CMOV_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   state_t cur;
   state_t nxt;
   cmd_t cmd;
   op_t op;
   logic req;
   logic exec;
   logic go;
   logic bad;
   logic do_push;
   logic do_pop;
   logic cond_ok;
   logic [2:0] rel_phys;
   logic [7:0] wadr;
   ext_t top_val;
   ext_t rel_val;
   ext_t pval;

   // Byte-lane merge of a write
   function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8+:8] = n[b*8+:8];
         end
      end
      return r;
   endfunction

   // Round-up decision from lsb, guard and sticky
   function automatic logic rnd(input logic s, input logic l, input logic g, input logic st, input logic [1:0] rc);
      case (rc)
         `RC_NEAREST: rnd = g & (st | l);
         `RC_DOWN: rnd = s & (g | st);
         `RC_UP: rnd = ~s & (g | st);
         default: rnd = 1'b0;
      endcase
   endfunction

   // Normalise a raw magnitude; exact, never rounds
   function automatic ext_t norm(input logic s, input logic [16:0] e, input logic [63:0] m);
      ext_t r;
      logic [6:0] n;
      n = 7'h00;
      for (int i = 0; i < 64; i++) begin
         if (m[i]) begin
            n = 7'(63 - i);
         end
      end
      r.s = s;
      r.m = m << n;
      r.e = (m == 64'h0) ? 15'h0000 : 15'(e - 17'(n));
      return r;
   endfunction

   // Single or double real to extended
   function automatic ext_t from_real(input logic [63:0] w, input logic dbl);
      logic s;
      logic [10:0] ex;
      logic [10:0] emax;
      logic [63:0] fr;
      logic [16:0] b;
      s = dbl ? w[63] : w[31];
      ex = dbl ? w[62:52] : {3'h0, w[30:23]};
      fr = dbl ? {w[51:0], 12'h000} : {w[22:0], 41'h0};
      emax = dbl ? 11'h7FF : 11'h0FF;
      b = dbl ? 17'h003FF : 17'h0007F;
      if (ex == emax) begin
         return {s, 15'h7FFF, 1'b1, fr[63:1]};
      end
      return norm(s, 17'((ex == 11'h0 ? 17'h1 : 17'(ex)) + `EXT_BIAS - b), {ex != 11'h0, fr[63:1]});
   endfunction

   // Extended to single or double; tiny results flush to signed zero
   function automatic logic [63:0] to_real(input ext_t x, input logic dbl, input logic [1:0] rc);
      logic [63:0] f;
      logic [63:0] fr;
      logic [63:0] rm;
      logic [17:0] e;
      logic [6:0] fb;
      logic [11:0] emax;
      logic [75:0] q;
      fb = dbl ? 7'h34 : 7'h17;
      emax = dbl ? 12'h7FF : 12'h0FF;
      f = {x.m[62:0], 1'b0};
      fr = f >> (7'h40 - fb);
      rm = f << fb;
      e = 18'({3'h0, x.e}) - 18'(`EXT_BIAS) + (dbl ? `DBL_BIAS : `SGL_BIAS);
      q = (76'(e[11:0]) << fb) + 76'(fr) + 76'(rnd(x.s, fr[0], rm[63], |rm[62:0], rc));
      if (x.e == 15'h7FFF) begin
         q = (76'(emax) << fb) | 76'(fr);
      end else if (x.m == 64'h0 || e[17] || e == 18'h0) begin
         q = 76'h0;
      end else if ((q >> fb) >= 76'(emax)) begin
         q = 76'(emax) << fb;
      end
      return dbl ? {x.s, q[62:0]} : {32'h0, x.s, q[30:0]};
   endfunction

   // Extended to rounded integer magnitude; bit 64 flags overflow
   function automatic logic [64:0] to_int(input ext_t x, input logic [1:0] rc);
      logic [129:0] fl;
      logic [16:0] sh;
      logic [64:0] v;
      logic g;
      logic st;
      if ({2'h0, x.e} > `INT_EXP) begin
         return {1'b1, 64'h0};
      end
      sh = `INT_EXP - {2'h0, x.e};
      if (sh > 17'h00042) begin
         v = 65'h0;
         g = 1'b0;
         st = |x.m;
      end else begin
         fl = {x.m, 66'h0} >> sh;
         v = {1'b0, fl[129:66]};
         g = fl[65];
         st = |fl[64:0];
      end
      return v + 65'(rnd(x.s, v[0], g, st, rc));
   endfunction

   // Packed decimal digits to binary
   function automatic logic [63:0] bcd2bin(input logic [71:0] d);
      logic [63:0] a;
      a = 64'h0;
      for (int k = 17; k >= 0; k--) begin
         a = 64'(a * 64'hA) + 64'(d[k*4+:4]);
      end
      return a;
   endfunction

   // Binary to packed decimal digits, shift-and-add-three
   function automatic logic [71:0] bin2bcd(input logic [63:0] b);
      logic [71:0] d;
      d = 72'h0;
      for (int i = 63; i >= 0; i--) begin
         for (int k = 0; k < 18; k++) begin
            if (d[k*4+:4] > 4'h4) begin
               d[k*4+:4] = d[k*4+:4] + 4'h3;
            end
         end
         d = {d[70:0], b[i]};
      end
      return d;
   endfunction

   // Bus request decode; a command carries no operand data of its own
   assign req = wb_cyc_i & wb_stb_i & ~cur.ack;
   assign wadr = {wb_adr_i[7:2], 2'b00};
   assign exec = req & wb_we_i & (wadr == `OFS_CMD);
   assign cmd = cmd_t'(wm(32'h0, wb_dat_i, wb_sel_i)); // [RULE_01]
   assign op = op_t'(cmd.op);
   assign go = exec & ~bad;
   assign rel_phys = cur.top + cmd.rel; // [RULE_24] [RULE_02]
   assign top_val = cur.stk[cur.top];
   assign rel_val = cur.stk[rel_phys];
   assign wb_dat_o = cur.rdat;
   assign wb_ack_o = cur.ack;

   // Move conditions read the integer flags image only
   always_comb begin
      case (cmd.sel) // [RULE_15] [RULE_16]
         3'h0: cond_ok = cur.iflags[`POS_CARRY];
         3'h1: cond_ok = ~cur.iflags[`POS_CARRY];
         3'h2: cond_ok = cur.iflags[`POS_ZERO];
         3'h3: cond_ok = ~cur.iflags[`POS_ZERO];
         3'h4: cond_ok = cur.iflags[`POS_CARRY] | cur.iflags[`POS_ZERO];
         3'h5: cond_ok = ~(cur.iflags[`POS_CARRY] | cur.iflags[`POS_ZERO]);
         3'h6: cond_ok = cur.iflags[`POS_PARITY];
         default: cond_ok = ~cur.iflags[`POS_PARITY];
      endcase
   end

   // Next state: register writes, command execution, read capture
   always_comb begin
      logic [64:0] iv;
      logic [63:0] lim;
      logic [63:0] ival;
      logic [63:0] rv;
      logic [71:0] km;
      logic [14:0] ke;
      logic iok;
      logic [31:0] cw;
      nxt = cur;
      rv = 64'h0;
      cw = wm({29'h0, cur.inv_mask, cur.rc}, wb_dat_i, wb_sel_i);
      pval = '0;
      do_push = 1'b0;
      do_pop = 1'b0;
      bad = 1'b0;
      km = 72'h0;
      ke = 15'h0;
      nxt.ack = req;
      iv = to_int(top_val, cur.rc);
      lim = 64'h1 << (cmd.sel == 3'h0 ? 6'hF : (cmd.sel == 3'h1 ? 6'h1F : 6'h3F));
      iok = ~iv[64] & ((iv[63:0] < lim) | (top_val.s & (iv[63:0] == lim)));
      ival = iok ? (top_val.s ? 64'(-iv[63:0]) : iv[63:0]) : lim;
      if (req && wb_we_i) begin
         case (wadr)
            `OFS_CTRL: begin
               nxt.rc = cw[1:0];
               nxt.inv_mask = cw[`POS_INV_MASK];
            end
            `OFS_FLAGS: nxt.iflags = 8'(wm({24'h0, cur.iflags}, wb_dat_i, wb_sel_i));
            `OFS_OPD0: nxt.opd[0] = wm(cur.opd[0], wb_dat_i, wb_sel_i);
            `OFS_OPD1: nxt.opd[1] = wm(cur.opd[1], wb_dat_i, wb_sel_i);
            `OFS_OPD2: nxt.opd[2] = wm(cur.opd[2], wb_dat_i, wb_sel_i);
            `OFS_PEEK_SEL: nxt.peek = 3'(wm({29'h0, cur.peek}, wb_dat_i, wb_sel_i));
            default: nxt.peek = cur.peek;
         endcase
      end
      // Operand words are filled by the processor's own addressing
      if (exec) begin // [RULE_03]
         case (op)
            load_real_push: begin
               do_push = 1'b1; // [RULE_05]
               case (cmd.sel)
                  3'h0: pval = from_real({32'h0, cur.opd[0]}, 1'b0);
                  3'h1: pval = from_real({cur.opd[1], cur.opd[0]}, 1'b1);
                  3'h2: pval = ext_t'({cur.opd[2][15:0], cur.opd[1], cur.opd[0]});
                  3'h3: pval = rel_val; // [RULE_06]
                  default: bad = 1'b1;
               endcase
            end
            load_integer_push: begin
               do_push = 1'b1;
               case (cmd.sel)
                  3'h0: rv = {{48{cur.opd[0][15]}}, cur.opd[0][15:0]};
                  3'h1: rv = {{32{cur.opd[0][31]}}, cur.opd[0]};
                  default: rv = {cur.opd[1], cur.opd[0]};
               endcase
               bad = cmd.sel > 3'h2;
               pval = norm(rv[63], `INT_EXP, rv[63] ? 64'(-rv) : rv); // [RULE_07]
            end
            load_bcd_push: begin
               do_push = 1'b1; // [RULE_08] [RULE_22]
               pval = norm(cur.opd[2][15], `INT_EXP, bcd2bin({cur.opd[2][7:0], cur.opd[1], cur.opd[0]}));
            end
            store_real, store_real_pop: begin
               do_pop = (op == store_real_pop); // [RULE_10]
               case (cmd.sel) // [RULE_09]
                  3'h0: nxt.res = 96'(to_real(top_val, 1'b0, cur.rc));
                  3'h1: nxt.res = 96'(to_real(top_val, 1'b1, cur.rc));
                  3'h2: nxt.res = 96'(top_val);
                  default: begin
                     bad = (op == store_real);
                     nxt.stk[rel_phys] = top_val; // [RULE_12]
                     nxt.valid[rel_phys] = 1'b1;
                  end
               endcase
            end
            store_integer, store_integer_pop: begin
               do_pop = (op == store_integer_pop);
               bad = (cmd.sel > 3'h2) | (~iok & ~cur.inv_mask);
               nxt.res = 96'(ival);
            end
            store_bcd_pop: begin
               do_pop = 1'b1;
               iok = ~iv[64] & (iv[63:0] < `BCD_LIMIT);
               bad = ~iok & ~cur.inv_mask;
               nxt.res = iok ? 96'({top_val.s, 7'h00, bin2bcd(iv[63:0])}) : 96'(`BCD_INDEF); // [RULE_21]
            end
            exchange_with_top: begin
               nxt.stk[rel_phys] = top_val; // [RULE_13]
               nxt.stk[cur.top] = rel_val;
               nxt.valid[rel_phys] = cur.valid[cur.top];
               nxt.valid[cur.top] = cur.valid[rel_phys];
            end
            conditional_move_to_top: begin
               bad = ~CMOV_PRESENT;
               if (cond_ok) begin
                  nxt.stk[cur.top] = rel_val; // [RULE_14]
                  nxt.valid[cur.top] = cur.valid[rel_phys];
               end
            end
            push_const: begin
               do_push = 1'b1; // [RULE_18]
               case (cmd.sel)
                  3'h0: begin ke = 15'h0; km = 72'h0; end
                  3'h1: begin ke = `K_ONE_E; km = `K_ONE_M; end
                  3'h2: begin ke = `K_PI_E; km = `K_PI_M; end
                  3'h3: begin ke = `K_L2T_E; km = `K_L2T_M; end
                  3'h4: begin ke = `K_L2E_E; km = `K_L2E_M; end
                  3'h5: begin ke = `K_LG2_E; km = `K_LG2_M; end
                  3'h6: begin ke = `K_LN2_E; km = `K_LN2_M; end
                  default: bad = 1'b1;
               endcase
               // Eight guard bits kept beyond the 64-bit significand
               pval = {1'b0, ke, 64'(km[71:8] + 64'(rnd(1'b0, km[8], km[7], |km[6:0], cur.rc)))}; // [RULE_19] [RULE_20]
            end
            default: bad = 1'b1;
         endcase
         nxt.refused = bad;
         if (bad) begin
            nxt.stk = cur.stk;
            nxt.valid = cur.valid;
            nxt.res = cur.res;
         end else if (do_push) begin
            nxt.top = cur.top - 3'h1; // [RULE_23]
            nxt.stk[3'(cur.top - 3'h1)] = pval; // [RULE_04]
            nxt.valid[3'(cur.top - 3'h1)] = 1'b1;
         end else if (do_pop) begin
            nxt.valid[cur.top] = 1'b0; // [RULE_11]
            nxt.top = cur.top + 3'h1;
         end
      end
      // Read data captured with the acknowledge; unmapped reads zero
      if (req && !wb_we_i) begin
         case (wadr)
            `OFS_CTRL: nxt.rdat = {29'h0, cur.inv_mask, cur.rc};
            `OFS_FLAGS: nxt.rdat = {24'h0, cur.iflags};
            `OFS_STATUS: nxt.rdat = {15'h0, cur.refused, cur.valid, 5'h0, cur.top};
            `OFS_OPD0: nxt.rdat = cur.opd[0];
            `OFS_OPD1: nxt.rdat = cur.opd[1];
            `OFS_OPD2: nxt.rdat = cur.opd[2];
            `OFS_RES0: nxt.rdat = cur.res[0];
            `OFS_RES1: nxt.rdat = cur.res[1];
            `OFS_RES2: nxt.rdat = cur.res[2];
            `OFS_FEATURE: nxt.rdat = {31'h0, CMOV_PRESENT}; // [RULE_17]
            `OFS_PEEK_SEL: nxt.rdat = {29'h0, cur.peek};
            `OFS_PEEK0: nxt.rdat = cur.stk[3'(cur.top + cur.peek)][31:0];
            `OFS_PEEK1: nxt.rdat = cur.stk[3'(cur.top + cur.peek)][63:32];
            `OFS_PEEK2: nxt.rdat = {cur.valid[3'(cur.top + cur.peek)], 15'h0, cur.stk[3'(cur.top + cur.peek)][79:64]};
            default: nxt.rdat = 32'h0;
         endcase
      end
   end

   // State register; reset clears the stack data and all its tags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur <= '0;
         cur.rc <= `CTRL_RC_RESET;
         cur.inv_mask <= `CTRL_MASK_RESET;
         cur.iflags <= `FLAGS_RESET;
         cur.top <= `TOP_RESET;
      end else begin
         cur <= nxt;
      end
   end

   property p_push_top;
      @(posedge clk_i) disable iff (rst_i)
      (go && do_push) |=> (cur.top == $past(cur.top) - 3'h1) && (top_val == $past(pval)) && cur.valid[cur.top];
   endproperty
   a_push_top: assert property (p_push_top) else $error("push did not land on new top"); // [RULE_23]

   property p_pop_top;
      @(posedge clk_i) disable iff (rst_i)
      (go && do_pop) |=> (cur.top == $past(cur.top) + 3'h1) && !cur.valid[3'(cur.top - 3'h1)];
   endproperty
   a_pop_top: assert property (p_pop_top) else $error("pop did not empty top"); // [RULE_11]

   property p_store_keeps;
      @(posedge clk_i) disable iff (rst_i)
      (go && (op == store_real || op == store_integer)) |=> $stable(cur.top) && $stable(cur.stk) && $stable(cur.valid);
   endproperty
   a_store_keeps: assert property (p_store_keeps) else $error("plain store changed the stack"); // [RULE_09]

   property p_xchg;
      @(posedge clk_i) disable iff (rst_i)
      (go && op == exchange_with_top) |=> (top_val == $past(rel_val));
   endproperty
   a_xchg: assert property (p_xchg) else $error("exchange lost selected value"); // [RULE_13]

   property p_cmov_false;
      @(posedge clk_i) disable iff (rst_i)
      (go && op == conditional_move_to_top && !cond_ok) |=> (top_val == $past(top_val)) && $stable(cur.top);
   endproperty
   a_cmov_false: assert property (p_cmov_false) else $error("false move changed top"); // [RULE_14]

   property p_cmov_be;
      @(posedge clk_i) disable iff (rst_i)
      (go && op == conditional_move_to_top && cmd.sel == 3'h4 && (cur.iflags[`POS_CARRY] || cur.iflags[`POS_ZERO]))
      |=> (top_val == $past(rel_val)) ##1 $stable(cur.top);
   endproperty
   a_cmov_be: assert property (p_cmov_be) else $error("below-or-equal move not taken"); // [RULE_16]

   property p_const_one;
      @(posedge clk_i) disable iff (rst_i)
      (go && op == push_const && cmd.sel == 3'h1) |=> (top_val == {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000});
   endproperty
   a_const_one: assert property (p_const_one) else $error("constant one wrong"); // [RULE_18]

   property p_pi_round;
      @(posedge clk_i) disable iff (rst_i)
      (go && op == push_const && cmd.sel == 3'h2) |=>
      (top_val.m == (($past(cur.rc) == `RC_UP || $past(cur.rc) == `RC_NEAREST) ? 64'hC90F_DAA2_2168_C235
      : 64'hC90F_DAA2_2168_C234));
   endproperty
   a_pi_round: assert property (p_pi_round) else $error("pi rounded wrongly"); // [RULE_20]

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus acknowledge not one cycle");
endmodule
`default_nettype wire

/* hw/fpu_stack_data_transfer_consts.svh */
/*
 Register offsets, reset values, rounding codes and constant table
 for the stack data-transfer unit.
 Assumes a byte-addressed bus with one 32-bit word per register.
*/
`ifndef FPU_STACK_DATA_TRANSFER_CONSTS_SVH
`define FPU_STACK_DATA_TRANSFER_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_FLAGS 8'h04
`define OFS_CMD 8'h08
`define OFS_STATUS 8'h0C
`define OFS_OPD0 8'h10
`define OFS_OPD1 8'h14
`define OFS_OPD2 8'h18
`define OFS_RES0 8'h1C
`define OFS_RES1 8'h20
`define OFS_RES2 8'h24
`define OFS_FEATURE 8'h28
`define OFS_PEEK_SEL 8'h2C
`define OFS_PEEK0 8'h30
`define OFS_PEEK1 8'h34
`define OFS_PEEK2 8'h38
`define CTRL_RC_RESET 2'h0
`define CTRL_MASK_RESET 1'h1
`define FLAGS_RESET 8'h00
`define TOP_RESET 3'h0
`define POS_CARRY 0
`define POS_PARITY 2
`define POS_ZERO 6
`define POS_INV_MASK 2
`define POS_REFUSED 16
`define RC_NEAREST 2'h0
`define RC_DOWN 2'h1
`define RC_UP 2'h2
`define RC_ZERO 2'h3
`define EXT_BIAS 17'h03FFF
`define DBL_BIAS 18'h003FF
`define SGL_BIAS 18'h0007F
`define INT_EXP 17'h0403E
`define BCD_LIMIT 64'h0DE0_B6B3_A764_0000
`define BCD_INDEF 80'hFFFF_0000_0000_0000_0000
`define K_ONE_E 15'h3FFF
`define K_ONE_M 72'h80_0000_0000_0000_0000
`define K_PI_E 15'h4000
`define K_PI_M 72'hC9_0FDA_A221_68C2_34C4
`define K_L2T_E 15'h4000
`define K_L2T_M 72'hD4_9A78_4BCD_1B8A_FE49
`define K_L2E_E 15'h3FFF
`define K_L2E_M 72'hB8_AA3B_295C_17F0_BBBE
`define K_LG2_E 15'h3FFD
`define K_LG2_M 72'h9A_209A_84FB_CFF7_988F
`define K_LN2_E 15'h3FFE
`define K_LN2_M 72'hB1_7217_F7D1_CF79_ABC9
`endif

/* hw/fpu_stack_data_transfer_pkg.sv */
/*
 Types of the stack data-transfer unit: extended value, command word,
 operation codes and the whole module state.
 Assumes an eight-entry stack.
*/
`default_nettype none
package fpu_stack_data_transfer_pkg;
   typedef struct packed {
      logic s;
      logic [14:0] e;
      logic [63:0] m;
   } ext_t;
   typedef struct packed {
      logic [20:0] pad;
      logic [2:0] sel;
      logic [2:0] rel;
      logic [4:0] op;
   } cmd_t;
   typedef enum logic [4:0] {
      op_nop, load_real_push, load_integer_push, load_bcd_push,
      store_real, store_integer, store_real_pop, store_integer_pop,
      store_bcd_pop, exchange_with_top, conditional_move_to_top, push_const
   } op_t;
   typedef struct packed {
      ext_t [7:0] stk;
      logic [7:0] valid;
      logic [2:0] top;
      logic [1:0] rc;
      logic inv_mask;
      logic [7:0] iflags;
      logic [2:0][31:0] opd;
      logic [2:0][31:0] res;
      logic [2:0] peek;
      logic refused;
      logic ack;
      logic [31:0] rdat;
   } state_t;
endpackage
`default_nettype wire

/* tb/cpu_side_model.sv */
/*
 Processor-side model: issues classic Wishbone cycles into the unit.
 Assumes a slave that answers with a registered one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
   // Clock
   input wire logic clk_i,
   // Wishbone master
   input wire logic ack_i,
   input wire logic [31:0] rdat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] wdat_o
);
   // Idle bus at time zero
   initial begin
      cyc_o = 1'h0;
      stb_o = 1'h0;
      we_o = 1'h0;
      adr_o = 8'h00;
      sel_o = 4'hF;
      wdat_o = 32'h0;
   end
   // One cycle; a missing ack is cut short by the bench timeout
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'h1;
      stb_o <= 1'h1;
      we_o <= we;
      adr_o <= a;
      wdat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'h1);
      q = rdat_i;
      cyc_o <= 1'h0;
      stb_o <= 1'h0;
      wdat_o <= ~d; // Stale data never looks valid
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench of the stack data-transfer unit.
 Assumes the register map and command word of the unit's header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpu_stack_data_transfer_consts.svh"
module tb import fpu_stack_data_transfer_pkg::*;;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [31:0] rng = 32'hD41A0A49;
   logic [2:0] t = 3'h0;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   fpu_stack_data_transfer fpu_stack_data_transfer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack));
   cpu_side_model cpu_inst (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Exact conversion of a signed 32-bit integer
   function automatic ext_t int2ext(input logic [31:0] v);
      logic [31:0] a;
      int p;
      ext_t r;
      r = '0;
      if (v == 32'h0) return r;
      r.s = v[31];
      a = v[31] ? -v : v;
      p = 31;
      while (!a[p]) p--;
      r.e = 15'h3FFF + 15'(p);
      r.m = {a, 32'h0} << (31 - p);
      return r;
   endfunction
   // Constants carry 8 guard bits; all are positive
   function automatic ext_t konst(input int k, input logic [1:0] rc);
      logic [86:0] em;
      logic up;
      ext_t r;
      case (k)
         1: em = {`K_ONE_E, `K_ONE_M};
         2: em = {`K_PI_E, `K_PI_M};
         3: em = {`K_L2T_E, `K_L2T_M};
         4: em = {`K_L2E_E, `K_L2E_M};
         5: em = {`K_LG2_E, `K_LG2_M};
         6: em = {`K_LN2_E, `K_LN2_M};
         default: em = '0;
      endcase
      up = rc == `RC_UP ? em[7:0] != 8'h0 : rc == `RC_NEAREST ? (em[7:0] > 8'h80 || em[8:0] == 9'h180) : 1'h0;
      r = {1'h0, em[86:72], em[71:8] + 64'(up)};
      return r;
   endfunction
   function automatic logic cmov_ok(input logic [2:0] s, input logic [31:0] f);
      logic c;
      case (s[2:1])
         2'h0: c = f[`POS_CARRY];
         2'h1: c = f[`POS_ZERO];
         2'h2: c = f[`POS_CARRY] | f[`POS_ZERO];
         default: c = f[`POS_PARITY];
      endcase
      return c ^ s[0];
   endfunction
   task automatic check(input string n, input logic [79:0] seen, input logic [79:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      cpu_inst.xfer(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      cpu_inst.xfer(1'h0, a, 32'h0, q);
   endtask
   task automatic cmd(input logic [4:0] op, input logic [2:0] i, input logic [2:0] s);
      wr(`OFS_CMD, {21'h0, s, i, op});
   endtask
   task automatic peek(input logic [2:0] i, output ext_t v);
      logic [31:0] w0, w1, w2;
      wr(`OFS_PEEK_SEL, {29'h0, i});
      rd(`OFS_PEEK0, w0);
      rd(`OFS_PEEK1, w1);
      rd(`OFS_PEEK2, w2);
      v = {w2[15:0], w1, w0};
   endtask
   task automatic stop_test;
      if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hang guard, well above the roughly 1700 cycles needed
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   // Main sequence; t mirrors the expected top pointer
   initial begin
      logic [31:0] q, f;
      ext_t a, b, c;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(`OFS_STATUS, q);
      check("status", q, 32'h0);
      rd(`OFS_FEATURE, q);
      check("feature", q[0], 1'h1);
      rd(8'hF0, q);
      check("unmapped", q, 32'h0);
      cmd(5'h00, 3'h0, 3'h0);
      rd(`OFS_STATUS, q);
      check("refused", q[16], 1'h1);
      for (int j = 0; j < 28; j++) begin
         wr(`OFS_CTRL, {29'h0, 1'h1, 2'(j / 7)});
         cmd(5'h0B, 3'h0, 3'(j % 7));
         t--;
         peek(3'h0, a);
         check("const", a, konst(j % 7, 2'(j / 7)));
         rd(`OFS_STATUS, q);
         check("top", q[2:0], t);
      end
      repeat (6) begin
         rng = lfsr(rng);
         wr(`OFS_OPD0, rng);
         cmd(5'h02, 3'h0, 3'h1);
         t--;
         peek(3'h0, a);
         check("int", a, int2ext(rng));
      end
      peek(3'h3, b);
      cmd(5'h01, 3'h3, 3'h3);
      peek(3'h0, a);
      check("copy", a, b);
      peek(3'h0, a);
      peek(3'h5, b);
      cmd(5'h09, 3'h5, 3'h0);
      peek(3'h0, c);
      check("xchg0", c, b);
      peek(3'h5, c);
      check("xchg5", c, a);
      // Fresh top each pass, else one taken move hides the rest
      for (int s = 0; s < 16; s++) begin
         if (s < 8) rng = lfsr(rng);
         f = s[3] ? ~rng : rng;
         wr(`OFS_FLAGS, f);
         wr(`OFS_OPD0, rng ^ 32'(s));
         cmd(5'h02, 3'h0, 3'h1);
         peek(3'h0, a);
         peek(3'h2, b);
         cmd(5'h0A, 3'h2, s[2:0]);
         peek(3'h0, c);
         check("cmov", c, cmov_ok(s[2:0], f) ? b : a);
      end
      rd(`OFS_STATUS, q);
      t = q[2:0];
      peek(3'h0, a);
      cmd(5'h06, 3'h0, 3'h2);
      rd(`OFS_RES0, f);
      c[31:0] = f;
      rd(`OFS_RES1, f);
      c[63:32] = f;
      rd(`OFS_RES2, f);
      c[79:64] = f[15:0];
      check("stpop", c, a);
      rd(`OFS_STATUS, q);
      check("poptop", q[2:0], 3'(t + 3'h1));
      check("poptag", q[8 + t], 1'h0);
      t++;
      wr(`OFS_OPD0, 32'hFFFF_FF85);
      cmd(5'h02, 3'h0, 3'h1);
      cmd(5'h05, 3'h0, 3'h1);
      rd(`OFS_RES0, q);
      check("stint", q, 32'hFFFF_FF85);
      rd(`OFS_STATUS, q);
      check("sttop", q[2:0], 3'(t - 3'h1));
      wr(`OFS_OPD0, 32'h0000_0987);
      cmd(5'h03, 3'h0, 3'h0);
      peek(3'h0, a);
      check("bcd", a, int2ext(32'h0000_03DB));
      cmd(5'h08, 3'h0, 3'h0);
      rd(`OFS_RES0, q);
      check("stbcd", q, 32'h0000_0987);
      peek(3'h0, a);
      cmd(5'h06, 3'h3, 3'h3);
      peek(3'h2, c);
      check("streg", c, a);
      // Real loads of +1.0 single and -2.0 double, then a double store
      wr(`OFS_OPD0, 32'h3F80_0000);
      cmd(5'h01, 3'h0, 3'h0);
      peek(3'h0, a);
      check("ldsgl", a, int2ext(32'h0000_0001));
      wr(`OFS_OPD1, 32'hC000_0000);
      wr(`OFS_OPD0, 32'h0000_0000);
      cmd(5'h01, 3'h0, 3'h1);
      peek(3'h0, a);
      check("lddbl", a, int2ext(32'hFFFF_FFFE));
      cmd(5'h04, 3'h0, 3'h1);
      rd(`OFS_RES1, q);
      check("stdbl", q, 32'hC000_0000);
      // Minus 2^62 exceeds 18 digits; masked invalid stores the indefinite
      cmd(5'h02, 3'h0, 3'h2);
      cmd(5'h08, 3'h0, 3'h0);
      rd(`OFS_RES2, q);
      check("bcdind", q[15:0], 16'hFFFF);
      stop_test();
   end
endmodule
`default_nettype wire
